// ---- shared/tvl_consts.vh ----
// Contract
// - Per variable, two of four sensor trips confirm
// - Auto trip needs two of four divisions
// - Full manual scram needs both manual channels
// - At most one division bypassed at once
// - Vote works with zero or one bypass
// - Bypass requests beyond one are refused
// - Extra sensors merge into four channels; tvl_trip_vote has one sensor per channel and feeds it to the merge twice
// - Division logic asynchronous, no shared time
// - Alarms on channel, system trips, bypasses
// - Parameters sent continuously to information system
// - Report tripped, bypassed, reset states
// - Condenser permissive at Run, inhibit otherwise
// - Send generation bus loss to condenser
// - Automation gets auto scram and mode
// - Alarm charging bypass in Startup or Run
// - Alarm channel tripped while sensors bypassed
// - Water level alarms at Level 3, 8
// - Alarm when auto scram test selector set
// - Scram de-energizes actuator output circuits
// - Manual resets ignored ten seconds after scram
`ifndef TVL_CONSTS_VH
`define TVL_CONSTS_VH
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TVL_NDIV 4
`define TVL_NVAR 8
`define TVL_NSNS 8
// ----------------------------------------------------------------
// Mode selector, one-hot positions
// ----------------------------------------------------------------
`define TVL_MODE_SHUT 4'h1
`define TVL_MODE_REFUEL 4'h2
`define TVL_MODE_START 4'h4
`define TVL_MODE_RUN 4'h8
// ----------------------------------------------------------------
// Water level thresholds and timing
// ----------------------------------------------------------------
`define TVL_LVL3 16'h0300
`define TVL_LVL8 16'h0800
`define TVL_CLK_MHZ 100
`define TVL_RST_INH_MS 10000
`define TVL_RST_INH_CYC (`TVL_RST_INH_MS * 1000 * `TVL_CLK_MHZ)
// ----------------------------------------------------------------
// Register bus map
// ----------------------------------------------------------------
`define TVL_REG_BYP 4'h0
`define TVL_REG_TST 4'h1
`define TVL_REG_STAT 4'h2
`define TVL_REG_ALM 4'h3
`define TVL_REG_SNS 4'h4
`endif

// ---- design/tvl_vote.v ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Two-of-four vote with bypass exclusion
// ----------------------------------------------------------------
module tvl_vote (
  // Inputs
  input wire [3:0] trip,
  input wire [3:0] byp,
  // Result
  output wire vote
);
  // Bypassed inputs are masked out of the count
  wire [3:0] act = trip & ~byp;
  wire [2:0] cnt = {2'b00, act[0]} + {2'b00, act[1]} + {2'b00, act[2]} + {2'b00, act[3]};
  // Two of four, still two of remaining three under one bypass
  assign vote = (cnt >= 3'h2);
endmodule // tvl_vote

// ---- design/tvl_merge.v ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Merge a variable's sensors into four division channels
// ----------------------------------------------------------------
module tvl_merge (
  // Sensor trips, two per division
  input wire [7:0] sns,
  // Division channels
  output wire [3:0] chn
);
  genvar g;
  // Any sensor of a division trips that division's channel
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_m
      assign chn[g] = sns[2*g] | sns[2*g+1];
    end
  endgenerate
endmodule // tvl_merge

// ---- design/tvl_trip_vote.v ----
`timescale 1ns/100ps
`include "tvl_consts.vh"
// ----------------------------------------------------------------
// Divisional trip voting, one division's logic on its own clock
// ----------------------------------------------------------------
module tvl_trip_vote #(
  parameter [31:0] RST_INH_CYC = `TVL_RST_INH_CYC
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire CLK_EN,
  // Avalon-MM slave
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // Field inputs, asynchronous
  input wire [31:0] SNS_TRIP,
  input wire [3:0] DIV_TRIP,
  input wire [1:0] MAN_SW,
  input wire [3:0] DIV_MAN_SW,
  input wire [3:0] MODE_SEL,
  input wire RESET_SW,
  input wire GEN_BUS_LOSS,
  input wire CHG_BYP_SW,
  input wire [15:0] WATER_LVL,
  // Actuator and trip outputs
  output reg ACT_PWR_ON,
  output reg DIV_TRIP_OUT,
  output reg AUTO_SCRAM,
  output reg MAN_SCRAM,
  // Interfacing systems
  output reg [3:0] COND_PERMIT,
  output reg [3:0] COND_INHIBIT,
  output reg COND_BUS_LOSS,
  output reg AUTO_SCRAM_PLANT,
  output reg [3:0] PLANT_MODE,
  // Console alarms
  output reg [3:0] ALM_CHN_TRIP,
  output reg ALM_AUTO_TRIP,
  output reg ALM_MAN_TRIP,
  output reg ALM_BYP,
  output reg ALM_CHG_BYP,
  output reg [3:0] ALM_TRIP_BYP,
  output reg ALM_LVL_LOW,
  output reg ALM_LVL_HIGH,
  output reg [3:0] ALM_TEST,
  output reg ALM_BYP_REFUSED,
  // Information system stream
  output reg [31:0] INFO_PARAMS,
  output reg [15:0] INFO_LVL,
  output reg [15:0] INFO_STATE
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; stage one read only by stage two
  reg [83:0] sy1_r;
  reg [83:0] sy2_r;
  wire [83:0] pins = {SNS_TRIP, DIV_TRIP, MAN_SW, DIV_MAN_SW, MODE_SEL, RESET_SW, GEN_BUS_LOSS,
                      CHG_BYP_SW, WATER_LVL, 19'h0};
  // Capture every asynchronous pin on the local clock only
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sy1_r <= 84'h0;
      sy2_r <= 84'h0;
    end else if (CLK_EN) begin
      sy1_r <= pins;
      sy2_r <= sy1_r;
    end
  end
  // Synchronised field
  wire [31:0] s_sns = sy2_r[83:52];
  wire [3:0] s_div = sy2_r[51:48];
  wire [1:0] s_man = sy2_r[47:46];
  wire [3:0] s_dman = sy2_r[45:42];
  wire [3:0] s_mode = sy2_r[41:38];
  wire s_rst = sy2_r[37];
  wire s_bus = sy2_r[36];
  wire s_chg = sy2_r[35];
  wire [15:0] s_lvl = sy2_r[34:19];
  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [3:0] byp_r; // Accepted division bypass, one-hot or zero
  reg [3:0] tst_r; // Auto scram test selectors
  reg refused_r; // A bypass request was refused
  reg [3:0] byp_nxt;
  reg ref_nxt;
  // Accept a bypass only if no other division stays bypassed
  always @* begin
    byp_nxt = byp_r;
    ref_nxt = refused_r;
    if (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `TVL_REG_BYP) begin
      if (AVS_WRITEDATA[3:0] == 4'h0 || AVS_WRITEDATA[3:0] == 4'h1 || AVS_WRITEDATA[3:0] == 4'h2 ||
          AVS_WRITEDATA[3:0] == 4'h4 || AVS_WRITEDATA[3:0] == 4'h8) begin
        if (byp_r == 4'h0 || AVS_WRITEDATA[3:0] == 4'h0 || AVS_WRITEDATA[3:0] == byp_r) begin
          byp_nxt = AVS_WRITEDATA[3:0];
          ref_nxt = 1'b0;
        end else begin
          ref_nxt = 1'b1;
        end
      end else begin
        ref_nxt = 1'b1;
      end
    end
  end
  // Bus slave: one wait cycle, then answer
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      byp_r <= 4'h0;
      tst_r <= 4'h0;
      refused_r <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else if (CLK_EN) begin
      AVS_WAITREQUEST <= 1'b1;
      if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        byp_r <= byp_nxt;
        refused_r <= ref_nxt;
        if (AVS_WRITE && AVS_ADDRESS == `TVL_REG_TST) begin
          tst_r <= AVS_WRITEDATA[3:0];
        end
        // Read mux, unmapped reads zero
        case (AVS_ADDRESS)
          `TVL_REG_BYP: AVS_READDATA <= {27'h0, refused_r, byp_r};
          `TVL_REG_TST: AVS_READDATA <= {28'h0, tst_r};
          `TVL_REG_STAT: AVS_READDATA <= {16'h0, INFO_STATE};
          `TVL_REG_ALM: AVS_READDATA <= {18'h0, ALM_TEST, ALM_TRIP_BYP, ALM_CHN_TRIP, ALM_BYP_REFUSED, ALM_LVL_HIGH};
          `TVL_REG_SNS: AVS_READDATA <= INFO_PARAMS;
          default: AVS_READDATA <= 32'h0;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Per-variable merge and vote
  // ----------------------------------------------------------------
  wire [31:0] chn; // Four channels per variable, variable-major, division bits within each variable
  wire [7:0] var_vote;
  genvar v;
  generate
    for (v = 0; v < `TVL_NVAR; v = v + 1) begin : g_var
      wire [7:0] sv = {s_sns[v*4+3], s_sns[v*4+3], s_sns[v*4+2], s_sns[v*4+2],
                       s_sns[v*4+1], s_sns[v*4+1], s_sns[v*4], s_sns[v*4]};
      tvl_merge u_merge (
        .sns(sv),
        .chn(chn[v*4+3:v*4])
      );
      tvl_vote u_vote (
        .trip(chn[v*4+3:v*4]),
        .byp(byp_r),
        .vote(var_vote[v])
      );
    end
  endgenerate
  // Division vote on division trip outputs, own division included
  wire [3:0] divs = {s_div[3:1], DIV_TRIP_OUT | s_div[0]};
  wire div_vote;
  tvl_vote u_divvote (
    .trip(divs),
    .byp(byp_r),
    .vote(div_vote)
  );
  // Per-channel trip condition over all variables
  reg [3:0] chn_any;
  integer k;
  always @* begin
    chn_any = 4'h0;
    for (k = 0; k < `TVL_NVAR; k = k + 1) begin
      chn_any = chn_any | chn[k*4 +: 4];
    end
  end
  // ----------------------------------------------------------------
  // Trip seal-in, reset inhibit and outputs
  // ----------------------------------------------------------------
  reg [31:0] inh_cnt_r; // Reset inhibit countdown
  wire auto_cause = (|var_vote) | (|tst_r) | s_dman[0];
  wire man_full = &s_man;
  wire mode_shut = (s_mode == `TVL_MODE_SHUT);
  wire scram_cause = div_vote | man_full | mode_shut;
  wire rst_ok = s_rst && (inh_cnt_r == 32'h0);
  // Sealed trips, released only by a permitted reset
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      DIV_TRIP_OUT <= 1'b0;
      AUTO_SCRAM <= 1'b0;
      MAN_SCRAM <= 1'b0;
      ACT_PWR_ON <= 1'b0;
      inh_cnt_r <= 32'h0;
    end else if (CLK_EN) begin
      // Division trip latch
      if (auto_cause) begin
        DIV_TRIP_OUT <= 1'b1;
      end else if (rst_ok) begin
        DIV_TRIP_OUT <= 1'b0;
      end
      // Auto scram latch
      if (div_vote) begin
        AUTO_SCRAM <= 1'b1;
      end else if (rst_ok) begin
        AUTO_SCRAM <= 1'b0;
      end
      // Manual scram latch
      if (man_full) begin
        MAN_SCRAM <= 1'b1;
      end else if (rst_ok) begin
        MAN_SCRAM <= 1'b0;
      end
      // Inhibit window restarts on each scram cause
      if (scram_cause) begin
        inh_cnt_r <= RST_INH_CYC;
      end else if (inh_cnt_r != 32'h0) begin
        inh_cnt_r <= inh_cnt_r - 32'h1;
      end
      // Power only when no scram sealed or pending
      ACT_PWR_ON <= !(scram_cause || AUTO_SCRAM || MAN_SCRAM);
    end
  end
  // ----------------------------------------------------------------
  // Alarms, status and interfacing outputs
  // ----------------------------------------------------------------
  // Alarms are live copies of their causes, no software clear
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ALM_CHN_TRIP <= 4'h0;
      ALM_AUTO_TRIP <= 1'b0;
      ALM_MAN_TRIP <= 1'b0;
      ALM_BYP <= 1'b0;
      ALM_CHG_BYP <= 1'b0;
      ALM_TRIP_BYP <= 4'h0;
      ALM_LVL_LOW <= 1'b0;
      ALM_LVL_HIGH <= 1'b0;
      ALM_TEST <= 4'h0;
      ALM_BYP_REFUSED <= 1'b0;
      COND_PERMIT <= 4'h0;
      COND_INHIBIT <= 4'hF;
      COND_BUS_LOSS <= 1'b0;
      AUTO_SCRAM_PLANT <= 1'b0;
      PLANT_MODE <= 4'h0;
      INFO_PARAMS <= 32'h0;
      INFO_LVL <= 16'h0;
      INFO_STATE <= 16'h0;
    end else if (CLK_EN) begin
      ALM_CHN_TRIP <= chn_any;
      ALM_AUTO_TRIP <= DIV_TRIP_OUT | AUTO_SCRAM;
      ALM_MAN_TRIP <= MAN_SCRAM | (|s_man);
      ALM_BYP <= |byp_r;
      ALM_CHG_BYP <= s_chg && (s_mode == `TVL_MODE_START || s_mode == `TVL_MODE_RUN);
      ALM_TRIP_BYP <= chn_any & byp_r;
      ALM_LVL_LOW <= (s_lvl <= `TVL_LVL3);
      ALM_LVL_HIGH <= (s_lvl >= `TVL_LVL8);
      ALM_TEST <= tst_r;
      ALM_BYP_REFUSED <= refused_r;
      // Run permissive to all four condenser divisions
      COND_PERMIT <= {4{s_mode == `TVL_MODE_RUN}};
      COND_INHIBIT <= {4{s_mode != `TVL_MODE_RUN}};
      COND_BUS_LOSS <= s_bus;
      AUTO_SCRAM_PLANT <= AUTO_SCRAM;
      PLANT_MODE <= s_mode;
      // Continuous parameter stream
      INFO_PARAMS <= s_sns;
      INFO_LVL <= s_lvl;
      INFO_STATE <= {s_dman, byp_r, var_vote[3:0], MAN_SCRAM, AUTO_SCRAM, DIV_TRIP_OUT, ACT_PWR_ON};
    end
  end
endmodule // tvl_trip_vote

// ---- bench/tvl_trip_vote_checker.sv ----
`timescale 1ns/100ps
`include "tvl_consts.vh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module tvl_trip_vote_checker (
  // Clock and control
  input logic CLK_SYS,
  input logic SYS_RST,
  input logic CLK_EN,
  // Bus handshake
  input logic AVS_READ,
  input logic AVS_WRITE,
  input logic AVS_WAITREQUEST,
  // Field inputs
  input logic [1:0] MAN_SW,
  input logic [3:0] MODE_SEL,
  input logic GEN_BUS_LOSS,
  input logic CHG_BYP_SW,
  input logic [15:0] WATER_LVL,
  input logic [31:0] SNS_TRIP,
  // Watched outputs
  input logic ACT_PWR_ON,
  input logic AUTO_SCRAM,
  input logic MAN_SCRAM,
  input logic [3:0] COND_PERMIT,
  input logic [3:0] COND_INHIBIT,
  input logic COND_BUS_LOSS,
  input logic AUTO_SCRAM_PLANT,
  input logic [3:0] PLANT_MODE,
  input logic ALM_CHG_BYP,
  input logic ALM_LVL_LOW,
  input logic ALM_LVL_HIGH,
  input logic [31:0] INFO_PARAMS,
  input logic [15:0] INFO_LVL
);
  logic [2:0] age_r; // Enabled cycles since reset
  logic rdy; // Synchronisers have settled
  // Saturating age count, so three-deep history is valid
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !CLK_EN) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  assign rdy = (age_r == 3'h7);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Request seen, then one-cycle answer
  sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
  sequence s_ans; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
  AST_BUS_ANS: assert property (s_req |=> s_ans) else $error("bus answer wrong");
  AST_COND: assert property (rdy |-> COND_PERMIT == {4{$past(MODE_SEL, 3) == `TVL_MODE_RUN}}
    && COND_INHIBIT == ~COND_PERMIT) else $error("condenser permit wrong");
  AST_BUS_LOSS: assert property (rdy |-> COND_BUS_LOSS == $past(GEN_BUS_LOSS, 3))
    else $error("bus loss wrong");
  AST_PLANT: assert property (rdy |-> PLANT_MODE == $past(MODE_SEL, 3)
    && AUTO_SCRAM_PLANT == $past(AUTO_SCRAM)) else $error("plant signals wrong");
  AST_INFO: assert property (rdy |-> INFO_PARAMS == $past(SNS_TRIP, 3)
    && INFO_LVL == $past(WATER_LVL, 3)) else $error("info stream wrong");
  AST_LVL: assert property (rdy |-> ALM_LVL_LOW == ($past(WATER_LVL, 3) <= `TVL_LVL3)
    && ALM_LVL_HIGH == ($past(WATER_LVL, 3) >= `TVL_LVL8)) else $error("level alarm wrong");
  AST_MAN: assert property (rdy && $rose(MAN_SCRAM) |-> $past(MAN_SW, 3) == 2'h3)
    else $error("manual scram without both");
  AST_PWR: assert property (AUTO_SCRAM || MAN_SCRAM |-> !ACT_PWR_ON)
    else $error("power on while scrammed");
  AST_CHG: assert property (rdy |-> ALM_CHG_BYP == ($past(CHG_BYP_SW, 3)
    && ($past(MODE_SEL, 3) & 4'hC) != 4'h0)) else $error("charging alarm wrong");
endmodule // tvl_trip_vote_checker
bind tvl_trip_vote tvl_trip_vote_checker u_chk (.*);

// ---- bench/tvl_plant_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Plant computer: flags channels that disagree
// ----------------------------------------------------------------
module tvl_plant_model (
  // Parameter stream
  input logic clk,
  input logic [31:0] params,
  // Disagreement alarm
  output logic mis
);
  // Any variable whose four channels are not all alike
  always @(posedge clk) begin
    mis <= 1'b0;
    for (int v = 0; v < 8; v++) begin
      if (params[v*4 +: 4] != 4'h0 && params[v*4 +: 4] != 4'hF) begin
        mis <= 1'b1;
      end
    end
  end
endmodule // tvl_plant_model

// ---- bench/tvl_trip_vote_bench.sv ----
`timescale 1ns/100ps
`include "tvl_consts.vh"
module tvl_trip_vote_bench;
  logic CLK_SYS, SYS_RST, CLK_EN, AVS_READ, AVS_WRITE, RESET_SW, GEN_BUS_LOSS, CHG_BYP_SW;
  logic [3:0] AVS_ADDRESS, DIV_TRIP, DIV_MAN_SW, MODE_SEL;
  logic [31:0] AVS_WRITEDATA, SNS_TRIP, rd;
  logic [1:0] MAN_SW;
  logic [15:0] WATER_LVL;
  wire [31:0] AVS_READDATA, INFO_PARAMS;
  wire AVS_WAITREQUEST, ACT_PWR_ON, DIV_TRIP_OUT, AUTO_SCRAM, MAN_SCRAM, COND_BUS_LOSS, AUTO_SCRAM_PLANT;
  wire ALM_AUTO_TRIP, ALM_MAN_TRIP, ALM_BYP, ALM_CHG_BYP, ALM_LVL_LOW, ALM_LVL_HIGH, ALM_BYP_REFUSED, mis;
  wire [3:0] COND_PERMIT, COND_INHIBIT, PLANT_MODE, ALM_CHN_TRIP, ALM_TRIP_BYP, ALM_TEST;
  wire [15:0] INFO_LVL, INFO_STATE;
  int failures, n_tests;
  tvl_trip_vote #(.RST_INH_CYC(20)) u_dut (.*);
  tvl_plant_model u_pc (.clk(CLK_SYS), .params(INFO_PARAMS), .mis(mis));
  // Clock, 10 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // Count and report one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  // One bus access, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0 && k < 50) begin
      @(posedge CLK_SYS);
      k++;
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (k >= 50) failures++;
  endtask
  // Manual channels, seal-in and reset hold-off
  task t_manual;
    @(posedge CLK_SYS) MAN_SW <= 2'h1;
    cyc(8);
    chk(MAN_SCRAM, 0);
    chk(ALM_MAN_TRIP, 1);
    @(posedge CLK_SYS) MAN_SW <= 2'h3;
    cyc(8);
    chk(MAN_SCRAM, 1);
    chk(ACT_PWR_ON, 0);
    @(posedge CLK_SYS) MAN_SW <= 2'h0;
    RESET_SW <= 1'b1;
    cyc(12);
    chk(MAN_SCRAM, 1);
    cyc(30);
    chk(MAN_SCRAM, 0);
  endtask
  // Sensor and division votes
  task t_vote;
    @(posedge CLK_SYS) SNS_TRIP <= 32'h100;
    cyc(8);
    chk(DIV_TRIP_OUT, 0);
    chk(mis, 1);
    @(posedge CLK_SYS) SNS_TRIP <= 32'h500;
    cyc(8);
    chk(DIV_TRIP_OUT, 1);
    chk(ALM_CHN_TRIP, 4'h5);
    chk(AUTO_SCRAM, 0);
    @(posedge CLK_SYS) DIV_TRIP <= 4'h8;
    cyc(8);
    chk(AUTO_SCRAM, 1);
    chk(ALM_AUTO_TRIP, 1);
    @(posedge CLK_SYS) SNS_TRIP <= 32'h0;
    DIV_TRIP <= 4'h0;
    cyc(40);
    chk(AUTO_SCRAM, 0);
  endtask
  // Bypass acceptance, refusal and vote masking
  task t_bypass;
    bus(1, 0, 1);
    cyc(6);
    chk(ALM_BYP, 1);
    bus(1, 0, 3);
    bus(1, 0, 4);
    bus(0, 0, 0);
    chk(rd, 32'h11);
    chk(ALM_BYP_REFUSED, 1);
    @(posedge CLK_SYS) SNS_TRIP <= 32'h3;
    cyc(8);
    chk(DIV_TRIP_OUT, 0);
    chk(ALM_TRIP_BYP, 4'h1);
    @(posedge CLK_SYS) SNS_TRIP <= 32'h7;
    cyc(8);
    chk(DIV_TRIP_OUT, 1);
    @(posedge CLK_SYS) SNS_TRIP <= 32'h0;
    bus(1, 0, 0);
    bus(0, 0, 0);
    chk(rd, 0);
    cyc(40);
  endtask
  // Every mode position, level thresholds at their edges
  task t_modes;
    logic [15:0] lv [4];
    lv = '{16'h0300, 16'h0301, 16'h07FF, 16'h0800};
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_SYS) MODE_SEL <= 4'h1 << i;
      CHG_BYP_SW <= 1'b1;
      GEN_BUS_LOSS <= i[0];
      WATER_LVL <= lv[i];
      cyc(6);
      chk(COND_PERMIT, (i == 3) ? 4'hF : 4'h0);
      chk(COND_INHIBIT, (i == 3) ? 4'h0 : 4'hF);
      chk(PLANT_MODE, 4'h1 << i);
      chk(COND_BUS_LOSS, i[0]);
      chk(ALM_CHG_BYP, i >= 2);
      chk({ALM_LVL_LOW, ALM_LVL_HIGH}, {i == 0, i == 3});
      chk(INFO_LVL, lv[i]);
      if (i == 0) chk(ACT_PWR_ON, 0);
    end
    @(posedge CLK_SYS) CHG_BYP_SW <= 1'b0;
    cyc(40);
  endtask
  // Test selector, status word and an unmapped place
  task t_test;
    bus(1, 1, 5);
    cyc(6);
    chk(ALM_TEST, 4'h5);
    bus(0, 2, 0);
    chk(rd[1], 1);
    bus(0, 4'hF, 0);
    chk(rd, 0);
    bus(1, 1, 0);
  endtask
  task complete_run;
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    {SYS_RST, CLK_EN, AVS_READ, AVS_WRITE, RESET_SW, GEN_BUS_LOSS, CHG_BYP_SW} = 7'h60;
    {AVS_ADDRESS, DIV_TRIP, DIV_MAN_SW, MAN_SW} = 14'h0;
    {AVS_WRITEDATA, SNS_TRIP} = 64'h0;
    MODE_SEL = `TVL_MODE_RUN;
    WATER_LVL = 16'h0500;
    repeat (6) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    cyc(8);
    t_manual;
    t_vote;
    t_bypass;
    t_modes;
    t_test;
    complete_run;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    failures++;
    complete_run;
  end
endmodule // tvl_trip_vote_bench
